// *** shared/tsa_pkg.sv ***
// Purpose: Shared constants and types for the thermometer scratchpad core.
// Assumes: 10 MHz core clock; byte and slot framing done outside the core.
// Notes: Long counts are top-level parameters; defaults derive from these.
package tsa_pkg;
  // ===========================================================
  // Function commands
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] CMD_RECALL = 8'hb8;
  localparam logic [7:0] CMD_READ_PWR = 8'hb4;
  // ===========================================================
  // Scratchpad map and field layout
  localparam int SP_TEMP_LO = 0;
  localparam int SP_TEMP_HI = 1;
  localparam int SP_HIGH_TRIG = 2;
  localparam int SP_LOW_TRIG = 3;
  localparam int SP_CONFIG = 4;
  localparam int SP_CRC = 8;
  localparam int SP_BITS = 72;
  localparam logic [6:0] SP_LAST_BIT = 7'h47;
  localparam logic [1:0] WR_LAST_IDX = 2'h2;
  localparam int CFG_RES_LO = 5;
  localparam int CFG_RES_HI = 6;
  localparam logic [7:0] CFG_FIXED = 8'h1f;
  localparam logic [1:0] RES_12BIT = 2'h3;
  localparam int ALARM_MSB = 11;
  localparam int ALARM_LSB = 4;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [7:0] NV_HIGH_DEF = 8'h4b;
  localparam logic [7:0] NV_LOW_DEF = 8'h46;
  localparam logic [7:0] RSVD_DEF = 8'hff;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  // ===========================================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int CONV_TIME_US = 750000;
  localparam int NV_WRITE_TIME_US = 10000;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
  localparam logic [3:0] RECALL_CYCLES = 4'h8;
  // ===========================================================
  // Types
  typedef enum logic [6:0] {
    TSA_IDLE = 7'b0000001,
    TSA_WRITE = 7'b0000010,
    TSA_READ = 7'b0000100,
    TSA_STAT_CONV = 7'b0001000,
    TSA_STAT_COPY = 7'b0010000,
    TSA_STAT_REC = 7'b0100000,
    TSA_POWER = 7'b1000000
  } tsa_proto_t;

  typedef struct packed {
    tsa_proto_t proto;
    logic [15:0] temp;
    logic [7:0] high_trigger;
    logic [7:0] low_trigger;
    logic [1:0] resolution;
    logic [1:0] wr_idx;
    logic [6:0] rd_idx;
    logic [22:0] conv_cnt;
    logic conv_busy;
    logic [16:0] copy_cnt;
    logic copy_busy;
    logic [3:0] rec_cnt;
    logic rec_busy;
    logic alarm;
    logic rd_bit;
    logic rd_valid;
    logic search_join;
    logic vdd_s1;
    logic vdd_s2;
  } tsa_state_t;

  // Eight-bit check over the first n bits of d, least significant first.
  function automatic logic [7:0] tsa_crc8(input logic [63:0] d,
                                           input int n);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (i < n) begin
        fb = c[0] ^ d[i];
        c = {1'b0, c[7:1]};
        if (fb) begin
          c = c ^ CRC_POLY_REFL;
        end
      end
    end
    return c;
  endfunction
endpackage

// *** src/tsa_core.sv ***
// Purpose: Function-command core of a single-line temperature sensor.
// Assumes: An outside slot engine delivers command and data bytes and
//   read-slot requests on this clock; the converter gives a sample.
// Notes: Nonvolatile bytes survive sys_rst, which stands for power-up.
// Function
// - Alarm compares only temperature bits 11..4 against the triggers.
// - Alarm sets when value is at or below low, or at/above high.
// - Alarm is re-evaluated after each conversion, clearing when back in range.
// - Alarm search: only a device with its alarm set takes part.
// - Power query: parasite device answers 0, external supply answers 1.
// - Identity: family byte low, 48-bit serial, then check byte on 56 bits.
// - Scratchpad bytes 0 and 1 show the temperature and are read-only.
// - Bytes 2, 3 hold high and low triggers; byte 4 is configuration.
// - Reserved bytes 5 to 7 are never changed by writes.
// - Byte 8 is a read-only check byte over bytes 0 to 7.
// - Write command stores bytes 2, 3, 4 in order, LSB first.
// - Read command sends the scratchpad from byte 0 LSB upward.
// - Copy command stores triggers and configuration into nonvolatile memory.
// - Power-up loads nonvolatile triggers and configuration into scratchpad.
// - Recall reloads from nonvolatile memory; slots read 0 busy, 1 done.
// - Configuration bits 6..5 select 9, 10, 11 or 12-bit resolution.
// - Resolution bits default to 12-bit at power-up.
// - Conversion time halves per resolution step down from 750 ms.
// - Configuration bit 7 reads 0, bits 4..0 read 1, writes ignored.
// - Temperature is a 16-bit sign-extended value with four fraction bits.
// - Convert starts a conversion; result lands in bytes 0 and 1.
// - All bytes travel least significant bit first.
// - Both check bytes use polynomial x^8 + x^5 + x^4 + 1.
`timescale 1ns/10ps
`default_nettype none
module tsa_core
  import tsa_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value.
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789ab, // Arbitrary.
  parameter logic [22:0] CONV_MAX_CYCLES = 23'(CONV_CYCLES),
  parameter logic [16:0] NV_WR_CYCLES = 17'(NV_WRITE_CYCLES)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic xact_reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic alarm_search,
  input wire logic [15:0] adc_sample,
  input wire logic vdd_present,
  output logic rd_valid,
  output logic rd_bit,
  output logic alarm_flag,
  output logic search_join,
  output logic conv_busy,
  output logic nv_busy,
  output logic [63:0] rom_code,
  output logic [15:0] temperature
);

  // ===========================================================
  // Identity code and nonvolatile store
  localparam logic [55:0] ROM_BODY = {SERIAL_NUMBER, FAMILY_CODE};
  localparam logic [63:0] ROM_WORD =
    {tsa_crc8({8'h00, ROM_BODY}, 56), ROM_BODY};

  // Index 0 high trigger, 1 low trigger, 2 resolution bits. No reset:
  // the contents must outlive sys_rst, so only the initialiser and a copy set them.
  logic [7:0] nv_mem [3] = '{NV_HIGH_DEF, NV_LOW_DEF,
                              {6'h00, RES_12BIT}};
  tsa_state_t st_ff;
  tsa_state_t nxt_st;
  logic [63:0] sp_body;
  logic [71:0] sp_image;
  logic [7:0] cfg_byte;
  logic [7:0] alarm_slice;
  logic [22:0] conv_len;
  logic nv_wr;

  // ===========================================================
  // Scratchpad image as seen by the read command
  always_comb begin
    cfg_byte = CFG_FIXED;
    cfg_byte[CFG_RES_HI] = st_ff.resolution[1];
    cfg_byte[CFG_RES_LO] = st_ff.resolution[0];
    sp_body = {RSVD_DEF, RSVD_DEF, RSVD_DEF, cfg_byte,
               st_ff.low_trigger, st_ff.high_trigger,
               st_ff.temp};
    sp_image = {tsa_crc8(sp_body, 64), sp_body};
  end

  // Resolution sets the conversion length by halving per step down.
  always_comb begin
    conv_len = CONV_MAX_CYCLES >> (RES_12BIT - st_ff.resolution);
  end

  assign alarm_slice = adc_sample[ALARM_MSB:ALARM_LSB];

  // ===========================================================
  // Next-state logic
  // Order of the blocks below matters. Later assignments win, so the
  // priority runs, from lowest to highest:
  //   1. The three timers (conversion, nonvolatile write, recall).
  //   2. The alarm search snapshot.
  //   3. Write-command data bytes.
  //   4. Read-slot answers.
  //   5. A new function command.
  //   6. A bus reset.
  // A command arriving in the same cycle as a data byte or a slot thus
  // ends the old exchange cleanly instead of mixing two of them.
  //
  // The timers are never cut short by a command or a bus reset. The
  // converter and the store would be left half done otherwise, and the
  // master is expected to wait them out anyway.
  //
  // A known limitation: a convert issued while a conversion runs only
  // switches the read-slot answer to conversion status; the running
  // window is not restarted, so its result reflects the older request.
  //
  // The alarm flag is written at one place only, at the end of a
  // conversion, so there is no set/clear race to arbitrate.
  //
  // The recall reload and a write byte could land in the same cycle.
  // The write byte wins, since it comes later in this process; a master
  // that mixes the two gets the value it wrote last.
  //
  // Read answers carry a separate valid pulse, so a slot that lands while
  // nothing is in progress still gets an idle answer of one.
  always_comb begin
    nxt_st = st_ff;
    nv_wr = 1'b0;
    nxt_st.rd_valid = 1'b0;
    nxt_st.search_join = 1'b0;
    // The supply pin is a pad; it passes two flip-flops first.
    nxt_st.vdd_s1 = vdd_present;
    nxt_st.vdd_s2 = st_ff.vdd_s1;

    // Conversion timer; the sample lands at the end of the window.
    if (st_ff.conv_busy) begin
      if (st_ff.conv_cnt <= 23'h000001) begin
        nxt_st.conv_busy = 1'b0;
        nxt_st.temp = adc_sample;
        // Signed compare so negative triggers behave as expected.
        nxt_st.alarm = ($signed(alarm_slice) <=
                        $signed(st_ff.low_trigger)) ||
                       ($signed(alarm_slice) >=
                        $signed(st_ff.high_trigger));
      end else begin
        nxt_st.conv_cnt = st_ff.conv_cnt - 23'h000001;
      end
    end

    // Nonvolatile write window; the store itself is taken at the start.
    if (st_ff.copy_busy) begin
      if (st_ff.copy_cnt <= 17'h00001) begin
        nxt_st.copy_busy = 1'b0;
      end else begin
        nxt_st.copy_cnt = st_ff.copy_cnt - 17'h00001;
      end
    end

    // Recall finishes by loading the scratchpad from the store.
    if (st_ff.rec_busy) begin
      if (st_ff.rec_cnt <= 4'h1) begin
        nxt_st.rec_busy = 1'b0;
        nxt_st.high_trigger = nv_mem[0];
        nxt_st.low_trigger = nv_mem[1];
        nxt_st.resolution = nv_mem[2][1:0];
      end else begin
        nxt_st.rec_cnt = st_ff.rec_cnt - 4'h1;
      end
    end

    // A search answer is only a snapshot of the alarm flag.
    if (alarm_search) begin
      nxt_st.search_join = st_ff.alarm;
    end

    // Bytes of the write command; reserved bytes have no write path.
    if (st_ff.proto == TSA_WRITE && wr_valid) begin
      case (st_ff.wr_idx)
        2'h0: nxt_st.high_trigger = wr_byte;
        2'h1: nxt_st.low_trigger = wr_byte;
        default: nxt_st.resolution = {wr_byte[CFG_RES_HI],
                                      wr_byte[CFG_RES_LO]};
      endcase
      if (st_ff.wr_idx == WR_LAST_IDX) begin
        nxt_st.proto = TSA_IDLE;
      end else begin
        nxt_st.wr_idx = st_ff.wr_idx + 2'h1;
      end
    end

    // Read slots; the answer depends on the command in progress.
    if (rd_req) begin
      nxt_st.rd_valid = 1'b1;
      case (st_ff.proto)
        TSA_READ: begin
          nxt_st.rd_bit = sp_image[st_ff.rd_idx];
          if (st_ff.rd_idx != SP_LAST_BIT) begin
            nxt_st.rd_idx = st_ff.rd_idx + 7'h01;
          end else begin
            nxt_st.proto = TSA_IDLE;
          end
        end
        TSA_STAT_CONV: nxt_st.rd_bit = ~st_ff.conv_busy;
        TSA_STAT_COPY: nxt_st.rd_bit = ~st_ff.copy_busy;
        TSA_STAT_REC: nxt_st.rd_bit = ~st_ff.rec_busy;
        TSA_POWER: nxt_st.rd_bit = st_ff.vdd_s2;
        default: nxt_st.rd_bit = 1'b1;
      endcase
    end

    // A new function command; a running conversion or copy is not restarted, but a recall is.
    if (cmd_valid) begin
      nxt_st.wr_idx = 2'h0;
      nxt_st.rd_idx = 7'h00;
      case (cmd_code)
        CMD_CONVERT: begin
          nxt_st.proto = TSA_STAT_CONV;
          if (!st_ff.conv_busy) begin
            nxt_st.conv_busy = 1'b1;
            nxt_st.conv_cnt = conv_len;
          end
        end
        CMD_WRITE_SP: nxt_st.proto = TSA_WRITE;
        CMD_READ_SP: nxt_st.proto = TSA_READ;
        CMD_COPY_SP: begin
          nxt_st.proto = TSA_STAT_COPY;
          if (!st_ff.copy_busy) begin
            nv_wr = 1'b1;
            nxt_st.copy_busy = 1'b1;
            nxt_st.copy_cnt = NV_WR_CYCLES;
          end
        end
        CMD_RECALL: begin
          nxt_st.proto = TSA_STAT_REC;
          nxt_st.rec_busy = 1'b1;
          nxt_st.rec_cnt = RECALL_CYCLES;
        end
        CMD_READ_PWR: nxt_st.proto = TSA_POWER;
        default: nxt_st.proto = TSA_IDLE;
      endcase
    end

    // A bus reset ends any exchange but lets timed jobs run out.
    if (xact_reset) begin
      nxt_st.proto = TSA_IDLE;
    end
  end

  // ===========================================================
  // State register; reset reloads triggers from the store.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.proto <= TSA_IDLE;
      st_ff.temp <= TEMP_RESET;
      st_ff.high_trigger <= nv_mem[0];
      st_ff.low_trigger <= nv_mem[1];
      st_ff.resolution <= nv_mem[2][1:0];
      st_ff.rd_bit <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Store write; kept apart so sys_rst never disturbs the contents.
  // The copy takes the scratchpad values of the command cycle; later
  // writes during the window do not reach the store.
  always_ff @(posedge clock) begin
    if (nv_wr && !sys_rst) begin
      nv_mem[0] <= st_ff.high_trigger;
      nv_mem[1] <= st_ff.low_trigger;
      nv_mem[2] <= {6'h00, st_ff.resolution};
    end
  end

  // Identity word is held in a register so the output is a flop.
  always_ff @(posedge clock) begin
    rom_code <= ROM_WORD;
  end

  // ===========================================================
  // Outputs
  assign rd_valid = st_ff.rd_valid;
  assign rd_bit = st_ff.rd_bit;
  assign alarm_flag = st_ff.alarm;
  assign search_join = st_ff.search_join;
  assign conv_busy = st_ff.conv_busy;
  assign nv_busy = st_ff.copy_busy;
  assign temperature = st_ff.temp;

endmodule // tsa_core
`default_nettype wire

// *** verification/tsa_core_asserts.sv ***
// Purpose: Port-level checks for the thermometer core.
// Assumes: Bound with the same count parameters as the core.
// Notes: One clock domain, so default clocking is used.
`timescale 1ns/10ps
`default_nettype none
module tsa_core_asserts
  import tsa_pkg::*;
#(
  parameter logic [22:0] CONV_MAX_CYCLES = 23'(CONV_CYCLES),
  parameter logic [16:0] NV_WR_CYCLES = 17'(NV_WRITE_CYCLES)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rd_req,
  input wire logic alarm_search,
  input wire logic [15:0] adc_sample,
  input wire logic vdd_present,
  input wire logic rd_valid,
  input wire logic rd_bit,
  input wire logic alarm_flag,
  input wire logic search_join,
  input wire logic conv_busy,
  input wire logic nv_busy,
  input wire logic [63:0] rom_code,
  input wire logic [15:0] temperature
);
  // Window lengths as plain ints; full-size windows are far too long for
  // a delay range, so run counters below measure them instead.
  localparam int CMAX = int'(CONV_MAX_CYCLES);
  localparam int NMAX = int'(NV_WR_CYCLES);
  int conv_run;
  int copy_run;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Count consecutive busy cycles; cleared whenever the flag is low.
  always_ff @(posedge clock) begin
    if (sys_rst || !conv_busy) begin
      conv_run <= 0;
    end else begin
      conv_run <= conv_run + 1;
    end
  end
  // Same for the nonvolatile write window.
  always_ff @(posedge clock) begin
    if (sys_rst || !nv_busy) begin
      copy_run <= 0;
    end else begin
      copy_run <= copy_run + 1;
    end
  end
  // ==========================================================
  // Request sequences
  sequence s_cmd(logic [7:0] code);
    cmd_valid && cmd_code == code;
  endsequence
  sequence s_slot(logic [7:0] code);
    s_cmd(code) ##2 rd_req;
  endsequence
  // ==========================================================
  // Properties
  AST_RD_ANSWER: assert property (rd_req |=> rd_valid)
    else $error("read slot not answered");
  AST_CONV_TIME: assert property (s_cmd(CMD_CONVERT) ##0 !conv_busy
    |=> conv_busy [*8]) else $error("conv window");
  AST_CONV_BOUND: assert property (conv_busy |-> conv_run < CMAX)
    else $error("conversion too long");
  AST_COPY_TIME: assert property (s_cmd(CMD_COPY_SP) ##0 !nv_busy
    |=> nv_busy [*8]) else $error("copy window");
  AST_COPY_BOUND: assert property (nv_busy |-> copy_run < NMAX)
    else $error("copy window too long");
  AST_COPY_EXACT: assert property ($fell(nv_busy)
    |-> $past(copy_run) == NMAX - 1) else $error("copy window length");
  AST_TEMP_ONLY: assert property ($changed(temperature)
    |-> $fell(conv_busy)) else $error("temperature moved alone");
  AST_TEMP_LOAD: assert property ($fell(conv_busy)
    |-> temperature == $past(adc_sample)) else $error("sample not kept");
  AST_ROM_FIXED: assert property ($stable(rom_code))
    else $error("identity code moved");
  AST_POWER: assert property (s_slot(CMD_READ_PWR)
    |=> rd_valid && rd_bit == vdd_present) else $error("power answer");
  AST_RECALL: assert property (s_slot(CMD_RECALL)
    |=> rd_valid && !rd_bit) else $error("recall not busy");
  AST_SEARCH: assert property (alarm_search && !conv_busy
    |=> search_join == $past(alarm_flag)) else $error("search answer");
endmodule // tsa_core_asserts
bind tsa_core tsa_core_asserts #(.CONV_MAX_CYCLES(CONV_MAX_CYCLES),
  .NV_WR_CYCLES(NV_WR_CYCLES)) u_chk (.clock, .sys_rst, .cmd_valid,
  .cmd_code, .rd_req, .alarm_search, .adc_sample, .vdd_present, .rd_valid,
  .rd_bit, .alarm_flag, .search_join, .conv_busy, .nv_busy, .rom_code,
  .temperature);
`default_nettype wire

// *** verification/tsa_master_model.sv ***
// Purpose: Bus master model that frames commands, bytes and slots.
// Assumes: Strobes are taken at the edge after they are raised.
// Notes: A read slot left unanswered reads back as unknown.
`timescale 1ns/10ps
`default_nettype none
module tsa_master_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  output logic alarm_search,
  input wire logic rd_valid,
  input wire logic rd_bit,
  input wire logic search_join,
  input wire logic nv_busy
);
  // Strong pullup of a parasite bus: on from the cycle after the copy
  // command, well inside the allowed delay, for the whole write window.
  logic pullup_on;
  assign pullup_on = nv_busy;
  // ==========================================================
  // Idle levels from time zero.
  initial begin
    {cmd_valid, wr_valid, rd_req, alarm_search} = 4'h0;
    {cmd_code, wr_byte} = 16'h0000;
  end
  // One command (w=0) or data byte (w=1); the line stays quiet while
  // the nonvolatile write needs the strong pullup.
  task automatic put(input logic w, input logic [7:0] b);
    while (nv_busy) @(posedge clock);
    @(posedge clock);
    cmd_valid <= !w;
    wr_valid <= w;
    cmd_code <= b;
    wr_byte <= b;
    @(posedge clock);
    cmd_valid <= 1'b0;
    wr_valid <= 1'b0;
  endtask
  // Read (s=0) or alarm search (s=1) slots, gathered from bit 0 up.
  task automatic slot(input logic s, input int n, output logic [71:0] v);
    v = 'x;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rd_req <= !s;
      alarm_search <= s;
      @(posedge clock);
      rd_req <= 1'b0;
      alarm_search <= 1'b0;
      @(posedge clock);
      v[i] = s ? search_join : (rd_valid ? rd_bit : 1'bx);
    end
  endtask
endmodule // tsa_master_model
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the thermometer core.
// Assumes: Short count parameters; expected data built here.
// Notes: Bus reset input is held low throughout.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tsa_pkg::*;
();
  localparam logic [22:0] CONV_N = 23'h40;
  localparam logic [16:0] NV_N = 17'h10;
  localparam logic [7:0] FAM = 8'h3c; // Arbitrary value.
  localparam logic [47:0] SER = 48'h0a1b2c3d4e5f; // Arbitrary value.
  logic clock, sys_rst, vdd_present, cmd_valid, wr_valid, rd_req;
  logic alarm_search, rd_valid, rd_bit, alarm_flag, search_join;
  logic conv_busy, nv_busy;
  logic [7:0] cmd_code, wr_byte;
  logic [15:0] adc_sample, temperature;
  logic [63:0] rom_code;
  logic [71:0] v;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n;
  logic [1:0] t_res [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [15:0] t_smp [5] = '{16'h0050, 16'h0040, 16'hffc0, 16'hffb0,
    16'h7040};
  logic t_alm [5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
  tsa_core #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER),
    .CONV_MAX_CYCLES(CONV_N), .NV_WR_CYCLES(NV_N)) dut (.clock, .sys_rst,
    .xact_reset(1'b0), .cmd_valid, .cmd_code, .wr_valid, .wr_byte, .rd_req,
    .alarm_search, .adc_sample, .vdd_present, .rd_valid, .rd_bit,
    .alarm_flag, .search_join, .conv_busy, .nv_busy, .rom_code,
    .temperature);
  tsa_master_model mst (.clock, .cmd_valid, .cmd_code, .wr_valid,
    .wr_byte, .rd_req, .alarm_search, .rd_valid, .rd_bit, .search_join,
    .nv_busy);
  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    end
    return c;
  endfunction
  // Nine-byte image; reserved bytes read as all ones.
  function automatic logic [71:0] img(input logic [15:0] t,
    input logic [7:0] h, l, f);
    return {crc({24'hffffff, f, l, h, t}, 64), 24'hffffff, f, l, h, t};
  endfunction
  task automatic chk(input string nm, input logic [71:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic sp(input logic [71:0] exp);
    mst.put(1'b0, CMD_READ_SP);
    mst.slot(1'b0, 72, v);
    chk("scratchpad", v, exp);
  endtask
  task automatic wsp(input logic [7:0] h, l, f);
    mst.put(1'b0, CMD_WRITE_SP);
    mst.put(1'b1, h);
    mst.put(1'b1, l);
    mst.put(1'b1, f);
  endtask
  // Busy length in cycles, bounded so a stuck flag cannot hang the run.
  task automatic busy_len(input logic nv, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while ((nv ? nv_busy : conv_busy) && k < 200);
    k--;
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock and hang guard; the run needs about 2300 cycles.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst, vdd_present, adc_sample} = {2'h3, 16'h0000};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    chk("rom", {8'h00, rom_code}, {8'h00, crc({8'h00, SER, FAM}, 56), SER, FAM});
    sp(img(16'h0550, NV_HIGH_DEF, NV_LOW_DEF, 8'h7f));
    wsp(8'h05, 8'hfb, 8'h80);
    mst.put(1'b1, 8'haa);
    sp(img(16'h0550, 8'h05, 8'hfb, 8'h1f));
    // Triggers 5 and -5, rewritten before each conversion.
    for (int i = 0; i < 5; i++) begin
      wsp(8'h05, 8'hfb, {1'b0, t_res[i], 5'h1f});
      adc_sample <= t_smp[i];
      mst.put(1'b0, CMD_CONVERT);
      busy_len(1'b0, n);
      chk("conv time", 72'(n), 72'(CONV_N >> (2'h3 - t_res[i])));
      chk("temperature", 72'(temperature), 72'(t_smp[i]));
      chk("alarm", 72'(alarm_flag), 72'(t_alm[i]));
      mst.slot(1'b1, 1, v);
      chk("search", 72'(v[0]), 72'(t_alm[i]));
      sp(img(t_smp[i], 8'h05, 8'hfb, {1'b0, t_res[i], 5'h1f}));
    end
    // Copy, overwrite, recall, then a power-up reload of the copy.
    wsp(8'h11, 8'h22, 8'h20);
    mst.put(1'b0, CMD_COPY_SP);
    busy_len(1'b1, n);
    chk("copy time", 72'(n), 72'(NV_N));
    wsp(8'h33, 8'h44, 8'h60);
    mst.put(1'b0, CMD_RECALL);
    mst.slot(1'b0, 1, v);
    chk("recall busy", 72'(v[0]), 72'h0);
    repeat (10) @(posedge clock);
    mst.slot(1'b0, 1, v);
    chk("recall done", 72'(v[0]), 72'h1);
    sp(img(16'h7040, 8'h11, 8'h22, 8'h3f));
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    sp(img(16'h0550, 8'h11, 8'h22, 8'h3f));
    for (int i = 0; i < 2; i++) begin
      vdd_present <= (i == 0);
      repeat (4) @(posedge clock);
      mst.put(1'b0, CMD_READ_PWR);
      mst.slot(1'b0, 1, v);
      chk("power", 72'(v[0]), 72'(i == 0));
    end
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
